/* File: hw/xor_test_map.svh */
// Constants for the pin test chain block: widths, counts and idle levels
`ifndef XOR_TEST_MAP_SVH
`define XOR_TEST_MAP_SVH

// Output slots in the pin map and chains actually built
`define XT_SLOT_COUNT     12
`define XT_CHAIN_COUNT    10

// Input pins folded by each chain; chains 5 to 9 all take the default width
`define XT_CHAIN0_WIDTH   60
`define XT_CHAIN1_WIDTH   33
`define XT_CHAIN2_WIDTH   44
`define XT_CHAIN3_WIDTH   41
`define XT_CHAIN4_WIDTH   40
`define XT_CHAIN_DEF_WIDTH 32

// Level shown on an output pin that carries no result
`define XT_IDLE_LEVEL     1'b0

`endif

/* File: hw/xor_test_pkg.sv */
// Types and helpers shared by the pin test chain files
package xor_test_pkg;

	// Entry sequence tracker
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_POWERED = 2'b10,
		ST_TEST    = 2'b11
	} entry_state_e;

	typedef int unsigned width_list_t [10];

	// Bit offset of a chain's first pin inside the packed pin bus
	function automatic int unsigned chain_base(
		input width_list_t  widths,
		input int unsigned  idx
	);
		int unsigned sum;
		sum = 0;
		for (int unsigned i = 0; i < 10; i++) begin
			if (i < idx) begin
				sum = sum + widths[i];
			end
		end
		return sum;
	endfunction : chain_base

endpackage : xor_test_pkg

/* File: hw/xor_fold.sv */
// One test chain: a row of XOR gates, each taking one input pin
`timescale 1ns/1ps

module xor_fold #(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] PINS,
	output logic                  PARITY
);

	logic [WIDTH:0] link;

	// Gate i folds pin i into the running value from gate i-1
	always_comb begin
		link[0] = 1'b0;
		for (int unsigned i = 0; i < WIDTH; i++) begin
			link[i+1] = link[i] ^ PINS[i];
		end
		PARITY = link[WIDTH];
	end

endmodule : xor_fold

/* File: hw/xor_chain_test.sv */
// Board pin test block: entry sequence, XOR chains and output pin pairs
//
// What this block does
// - Test mode entered through the entry pin; chain folding needs no clock.
// - No pin testing while reset-in is low; results valid after release.
// - Each chain is a row of XOR gates, one input pin per gate.
// - Ten chains are built although twelve output slots are mapped.
// - Full-width testing shows each result on both channel pins.
// - Shared mode shows a result only on the selected channel's pin.
// - Each chain output goes to a fixed pin pair; slots 10-11 carry the idle level.
// - Graphics strobe pairs sit on different chains of one channel group.
// - Chain 0 folds sixty pins onto its two dedicated test outputs.
`timescale 1ns/1ps
`include "xor_test_map.svh"

module xor_chain_test #(
	parameter int unsigned SLOTS       = `XT_SLOT_COUNT,
	parameter int unsigned CHAIN_COUNT = `XT_CHAIN_COUNT,
	parameter xor_test_pkg::width_list_t CHAIN_W = '{
		`XT_CHAIN0_WIDTH, `XT_CHAIN1_WIDTH, `XT_CHAIN2_WIDTH,
		`XT_CHAIN3_WIDTH, `XT_CHAIN4_WIDTH, `XT_CHAIN_DEF_WIDTH,
		`XT_CHAIN_DEF_WIDTH, `XT_CHAIN_DEF_WIDTH, `XT_CHAIN_DEF_WIDTH,
		`XT_CHAIN_DEF_WIDTH},
	parameter int unsigned PIN_TOTAL   =
		xor_test_pkg::chain_base(CHAIN_W, CHAIN_COUNT)
) (
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 RESET_IN_N,
	input  wire logic                 POWER_GOOD_IN,
	input  wire logic                 TEST_MODE_ENTRY_N,
	input  wire logic                 GFX_SIDEBAND_ADDR_BIT6_N,
	input  wire logic                 GFX_SIDEBAND_ADDR_BIT7_N,
	input  wire logic                 GFX_CMD_BYTE_ENABLE1,
	input  wire logic                 GFX_PORT_NEWER_MODE,
	input  wire logic                 HOST_CLOCK_POS,
	input  wire logic                 HOST_CLOCK_NEG,
	input  wire logic                 SHARED_MODE,
	input  wire logic                 CHANNEL_B_SEL,
	input  wire logic [PIN_TOTAL-1:0] CHAIN_PINS,
	output logic      [SLOTS-1:0]     CHAN_A_PINS,
	output logic      [SLOTS-1:0]     CHAN_B_PINS,
	output logic                      TEST_MODE_ACTIVE
);

	xor_test_pkg::entry_state_e state;
	xor_test_pkg::entry_state_e next_state;

	logic [CHAIN_COUNT-1:0] parity;
	logic [SLOTS-1:0]       slot_result;
	logic [SLOTS-1:0]       next_chan_a;
	logic [SLOTS-1:0]       next_chan_b;
	logic                   next_active;
	logic                   sideband_ok;
	logic                   entry_held;
	logic                   clock_pair_ok;
	logic                   chain0_ref;

	// One fold per chain; strobe pairs are split across chains by the
	// order in which the board wires pins onto the packed bus
	for (genvar g = 0; g < CHAIN_COUNT; g++) begin : g_chain
		localparam int unsigned BASE = xor_test_pkg::chain_base(CHAIN_W, g);
		xor_fold #(
			.WIDTH  (CHAIN_W[g])
		) u_fold (
			.PINS   (CHAIN_PINS[BASE +: CHAIN_W[g]]),
			.PARITY (parity[g])
		);
	end

	// Slots past the built chains carry the idle level
	always_comb begin
		slot_result = {SLOTS{`XT_IDLE_LEVEL}};
		slot_result[CHAIN_COUNT-1:0] = parity;
	end

	// Reference for chain 0 used only by the checks below
	assign chain0_ref = ^CHAIN_PINS[CHAIN_W[0]-1:0];

	// Sideband strap levels flip polarity in the newer port mode
	always_comb begin
		if (GFX_PORT_NEWER_MODE) begin
			sideband_ok = GFX_SIDEBAND_ADDR_BIT6_N
				& GFX_SIDEBAND_ADDR_BIT7_N
				& GFX_CMD_BYTE_ENABLE1;
		end else begin
			sideband_ok = ~GFX_SIDEBAND_ADDR_BIT6_N
				& ~GFX_SIDEBAND_ADDR_BIT7_N;
		end
		entry_held = sideband_ok & ~TEST_MODE_ENTRY_N;
	end

	// A static clock pair would let metastable input latches settle either
	// way, so results are only taken while the pair is complementary
	assign clock_pair_ok = HOST_CLOCK_POS ^ HOST_CLOCK_NEG;

	// Entry sequence: all low, power-good up, then reset-in released
	always_comb begin
		next_state = state;
		unique case (state)
			xor_test_pkg::ST_IDLE: begin
				if (entry_held && !POWER_GOOD_IN && !RESET_IN_N) begin
					next_state = xor_test_pkg::ST_ARMED;
				end
			end
			xor_test_pkg::ST_ARMED: begin
				if (!entry_held || RESET_IN_N) begin
					next_state = xor_test_pkg::ST_IDLE;
				end else if (POWER_GOOD_IN) begin
					next_state = xor_test_pkg::ST_POWERED;
				end
			end
			xor_test_pkg::ST_POWERED: begin
				if (!entry_held || !POWER_GOOD_IN) begin
					next_state = xor_test_pkg::ST_IDLE;
				end else if (RESET_IN_N) begin
					next_state = xor_test_pkg::ST_TEST;
				end
			end
			xor_test_pkg::ST_TEST: begin
				if (TEST_MODE_ENTRY_N || !POWER_GOOD_IN) begin
					next_state = xor_test_pkg::ST_IDLE;
				end else if (!RESET_IN_N) begin
					next_state = xor_test_pkg::ST_POWERED;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= xor_test_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Output pin pairs: mirrored in full width, one channel when shared
	always_comb begin
		next_chan_a = CHAN_A_PINS;
		next_chan_b = CHAN_B_PINS;
		next_active = (state == xor_test_pkg::ST_TEST);
		if (state != xor_test_pkg::ST_TEST) begin
			next_chan_a = {SLOTS{`XT_IDLE_LEVEL}};
			next_chan_b = {SLOTS{`XT_IDLE_LEVEL}};
		end else if (clock_pair_ok) begin
			if (!SHARED_MODE) begin
				next_chan_a = slot_result;
				next_chan_b = slot_result;
			end else if (!CHANNEL_B_SEL) begin
				next_chan_a = slot_result;
				next_chan_b = {SLOTS{`XT_IDLE_LEVEL}};
			end else begin
				next_chan_a = {SLOTS{`XT_IDLE_LEVEL}};
				next_chan_b = slot_result;
			end
		end
	end

	// Pins come straight from flops so chain glitches never reach the board
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CHAN_A_PINS      <= {SLOTS{`XT_IDLE_LEVEL}};
			CHAN_B_PINS      <= {SLOTS{`XT_IDLE_LEVEL}};
			TEST_MODE_ACTIVE <= 1'b0;
		end else begin
			CHAN_A_PINS      <= next_chan_a;
			CHAN_B_PINS      <= next_chan_b;
			TEST_MODE_ACTIVE <= next_active;
		end
	end

	// Checks on the entry sequence and on the pin pairs

	property p_entry_powered;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_ARMED && entry_held && POWER_GOOD_IN
			&& !RESET_IN_N) |=> (state == xor_test_pkg::ST_POWERED);
	endproperty
	a_entry_powered: assert property (p_entry_powered)
		else $error("power-good rise did not advance the entry sequence");

	property p_no_test_in_reset;
		@(posedge CORE_CLK) disable iff (!RST_N)
		!RESET_IN_N |=> ##1 !TEST_MODE_ACTIVE;
	endproperty
	a_no_test_in_reset: assert property (p_no_test_in_reset)
		else $error("test mode shown while reset-in was low");

	property p_idle_pins;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state != xor_test_pkg::ST_TEST) |=>
			(CHAN_A_PINS == {SLOTS{`XT_IDLE_LEVEL}}
			&& CHAN_B_PINS == {SLOTS{`XT_IDLE_LEVEL}});
	endproperty
	a_idle_pins: assert property (p_idle_pins)
		else $error("pins left idle level outside test mode");

	property p_full_mirror;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && !SHARED_MODE && clock_pair_ok)
			|=> (CHAN_A_PINS == CHAN_B_PINS
			&& CHAN_A_PINS[CHAIN_COUNT-1:0] == $past(parity));
	endproperty
	a_full_mirror: assert property (p_full_mirror)
		else $error("full-width pins do not both carry the results");

	property p_shared_a;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && SHARED_MODE && !CHANNEL_B_SEL
			&& clock_pair_ok) |=>
			(CHAN_B_PINS == {SLOTS{`XT_IDLE_LEVEL}}
			&& CHAN_A_PINS[CHAIN_COUNT-1:0] == $past(parity));
	endproperty
	a_shared_a: assert property (p_shared_a)
		else $error("channel A selection not shown on channel A only");

	property p_shared_b;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && SHARED_MODE && CHANNEL_B_SEL
			&& clock_pair_ok) |=>
			(CHAN_A_PINS == {SLOTS{`XT_IDLE_LEVEL}}
			&& CHAN_B_PINS[CHAIN_COUNT-1:0] == $past(parity));
	endproperty
	a_shared_b: assert property (p_shared_b)
		else $error("channel B selection not shown on channel B only");

	property p_chain0_parity;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && !SHARED_MODE && clock_pair_ok)
			|=> (CHAN_A_PINS[0] == $past(chain0_ref)
			&& CHAN_B_PINS[0] == $past(chain0_ref));
	endproperty
	a_chain0_parity: assert property (p_chain0_parity)
		else $error("chain 0 pins differ from parity of its pins");

	property p_toggle_inverts;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && !SHARED_MODE && clock_pair_ok
			&& $past(state) == xor_test_pkg::ST_TEST
			&& $past(!SHARED_MODE && clock_pair_ok)
			&& $countones(CHAIN_PINS[CHAIN_W[0]-1:0]
				^ $past(CHAIN_PINS[CHAIN_W[0]-1:0])) == 1)
			|=> (CHAN_A_PINS[0] != $past(CHAN_A_PINS[0]));
	endproperty
	a_toggle_inverts: assert property (p_toggle_inverts)
		else $error("single pin toggle did not invert chain 0");

	property p_spare_slots;
		@(posedge CORE_CLK) disable iff (!RST_N)
		1'b1 |=> (CHAN_A_PINS[SLOTS-1:CHAIN_COUNT]
			== {(SLOTS-CHAIN_COUNT){`XT_IDLE_LEVEL}});
	endproperty
	a_spare_slots: assert property (p_spare_slots)
		else $error("unbuilt chain slot left the idle level");

	property p_static_clock_hold;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(state == xor_test_pkg::ST_TEST && !clock_pair_ok)
			|=> $stable(CHAN_A_PINS) && $stable(CHAN_B_PINS);
	endproperty
	a_static_clock_hold: assert property (p_static_clock_hold)
		else $error("pins changed while host clock pair was static");

endmodule : xor_chain_test

/* File: verif/ate_model.sv */
// Board test equipment model: entry straps and host clock pair
`timescale 1ns/1ps

module ate_model (
	input  wire logic clk,
	output logic      reset_in_n,
	output logic      power_good_in,
	output logic      test_mode_entry_n,
	output logic      gfx_sideband_addr_bit6_n,
	output logic      gfx_sideband_addr_bit7_n,
	output logic      gfx_cmd_byte_enable1,
	output logic      newer_mode,
	output logic      host_clock_pos,
	output logic      host_clock_neg
);
	logic run;

	// Idle straps: entry released, board held in reset
	initial begin
		{reset_in_n, power_good_in, newer_mode} = 3'h0;
		gfx_cmd_byte_enable1 = 1'b0;
		test_mode_entry_n = 1'b1;
		gfx_sideband_addr_bit6_n = 1'b1;
		gfx_sideband_addr_bit7_n = 1'b1;
		host_clock_pos = 1'b0;
		host_clock_neg = 1'b1;
		run = 1'b1;
	end

	// Neg copies the old pos: complementary while running, equal once frozen
	always @(posedge clk) begin
		if (run)
			host_clock_pos <= #1 ~host_clock_pos;
		host_clock_neg <= #1 host_clock_pos;
	end

	// Reset-in change, then two edges so state and outputs settle
	task automatic rst_in(input logic v);
		@(posedge clk);
		#1;
		reset_in_n = v;
		repeat (2) @(posedge clk);
	endtask : rst_in

	// Entry walk: all low, then power good, then reset-in released
	task automatic enter(input logic nm);
		@(posedge clk);
		#1;
		newer_mode = nm;
		gfx_sideband_addr_bit6_n = nm;
		gfx_sideband_addr_bit7_n = nm;
		gfx_cmd_byte_enable1 = nm;
		test_mode_entry_n = 1'b0;
		power_good_in = 1'b0;
		reset_in_n = 1'b0;
		@(posedge clk);
		#1;
		power_good_in = 1'b1;
		rst_in(1'b1);
	endtask : enter

	// Drop out of test mode entirely
	task automatic leave();
		@(posedge clk);
		#1;
		test_mode_entry_n = 1'b1;
		power_good_in = 1'b0;
		reset_in_n = 1'b0;
	endtask : leave

	// Start or freeze the host clock pair
	task automatic pair(input logic v);
		@(posedge clk);
		#1;
		run = v;
	endtask : pair
endmodule : ate_model

/* File: verif/tb.sv */
// Self-checking bench for the pin test chain block
`timescale 1ns/1ps
`include "xor_test_map.svh"

module tb;
	localparam int PT = 377;
	localparam int W [10] = '{`XT_CHAIN0_WIDTH, `XT_CHAIN1_WIDTH,
		`XT_CHAIN2_WIDTH, `XT_CHAIN3_WIDTH, `XT_CHAIN4_WIDTH,
		`XT_CHAIN_DEF_WIDTH, `XT_CHAIN_DEF_WIDTH, `XT_CHAIN_DEF_WIDTH,
		`XT_CHAIN_DEF_WIDTH, `XT_CHAIN_DEF_WIDTH};

	typedef struct packed {
		logic [11:0] a;
		logic [11:0] b;
		logic        act;
	} exp_s;

	logic          clk, rst_n, sh, bsel, act;
	logic          rin_n, pg, ent_n, s6_n, s7_n, be1, nm, hp, hn;
	logic [PT-1:0] pins, p;
	logic [11:0]   ca, cb;
	exp_s          q [$];
	exp_s          last, e;
	int            b, seed;
	int            bad_count = 0;
	int            cmp_count = 0;
	int            cycles = 0;

	xor_chain_test dut (.CORE_CLK(clk), .RST_N(rst_n),
		.RESET_IN_N(rin_n), .POWER_GOOD_IN(pg), .TEST_MODE_ENTRY_N(ent_n),
		.GFX_SIDEBAND_ADDR_BIT6_N(s6_n), .GFX_SIDEBAND_ADDR_BIT7_N(s7_n),
		.GFX_CMD_BYTE_ENABLE1(be1), .GFX_PORT_NEWER_MODE(nm),
		.HOST_CLOCK_POS(hp), .HOST_CLOCK_NEG(hn), .SHARED_MODE(sh),
		.CHANNEL_B_SEL(bsel), .CHAIN_PINS(pins), .CHAN_A_PINS(ca),
		.CHAN_B_PINS(cb), .TEST_MODE_ACTIVE(act));

	ate_model ate (.clk(clk), .reset_in_n(rin_n), .power_good_in(pg),
		.test_mode_entry_n(ent_n), .gfx_sideband_addr_bit6_n(s6_n),
		.gfx_sideband_addr_bit7_n(s7_n), .gfx_cmd_byte_enable1(be1),
		.newer_mode(nm), .host_clock_pos(hp), .host_clock_neg(hn));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Run is about 90 cycles; the ceiling leaves a wide margin
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 1000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic [11:0] x, s);
		cmp_count = cmp_count + 1;
		if (x !== s) begin
			bad_count = bad_count + 1;
			$display("unexpected %s: expected %h, seen %h", n, x, s);
		end
	endtask : chk

	// Test mode flag compare kept apart from the pin words
	task automatic chk_act(input logic x, s);
		cmp_count = cmp_count + 1;
		if (x !== s) begin
			bad_count = bad_count + 1;
			$display("unexpected active: expected %b, seen %b", x, s);
		end
	endtask : chk_act

	// Notes are compared half a cycle after the capture they predict
	always @(negedge clk) begin
		if (q.size() != 0) begin
			e = q.pop_front();
			chk("chan_a", e.a, ca);
			chk("chan_b", e.b, cb);
			chk_act(e.act, act);
		end
	end

	// Parity of each chain slice; slots 10 and 11 stay idle
	function automatic logic [11:0] fold(input logic [PT-1:0] v);
		logic [11:0] r;
		int base;
		r = 12'h000;
		base = 0;
		for (int g = 0; g < 10; g++) begin
			for (int k = 0; k < W[g]; k++)
				r[g] = r[g] ^ v[base + k];
			base = base + W[g];
		end
		return r;
	endfunction : fold

	function automatic logic [PT-1:0] rnd();
		logic [383:0] t;
		for (int i = 0; i < 12; i++)
			t[i*32 +: 32] = $random(seed);
		return t[PT-1:0];
	endfunction : rnd

	// Mode m: 0 outside test, 1 live pair, 2 frozen pair keeps old pins
	task automatic step(input logic [PT-1:0] v, input logic s, c,
		input int m);
		logic [11:0] r;
		@(posedge clk);
		#1;
		pins = v;
		sh = s;
		bsel = c;
		@(posedge clk);
		#1;
		r = fold(v);
		if (m == 1) begin
			last.a = (s && c) ? 12'h000 : r;
			last.b = (s && !c) ? 12'h000 : r;
		end else if (m == 0) begin
			last.a = 12'h000;
			last.b = 12'h000;
		end
		last.act = (m != 0);
		q.push_back(last);
	endtask : step

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	initial begin
		{rst_n, sh, bsel} = 3'h0;
		pins = '0;
		seed = 66;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		step(rnd(), 1'($random(seed)), 1'($random(seed)), 0);
		done("before entry");
		ate.enter(1'b0);
		// Channel select must not matter while both pins mirror
		for (int i = 0; i < 8; i++)
			step(rnd(), 1'b0, 1'($random(seed)), 1);
		done("full width");
		// Base pattern first, so the first toggle flips one chain 0 pin
		p = rnd();
		step(p, 1'b0, 1'b0, 1);
		b = 0;
		// One chain at a time, so strobe-sharing chains never run together
		for (int g = 0; g < 10; g++) begin
			p[b + $unsigned($random(seed)) % W[g]] ^= 1'b1;
			b = b + W[g];
			step(p, 1'b0, 1'b0, 1);
		end
		done("single pin toggle");
		for (int i = 0; i < 4; i++)
			step(rnd(), 1'b1, i[0], 1);
		done("shared channel");
		ate.pair(1'b0);
		step(rnd(), 1'b0, 1'b0, 2);
		ate.pair(1'b1);
		step(rnd(), 1'b0, 1'b0, 1);
		done("frozen host clock");
		ate.rst_in(1'b0);
		step(rnd(), 1'b0, 1'b0, 0);
		ate.rst_in(1'b1);
		step(rnd(), 1'b0, 1'b0, 1);
		done("reset-in again");
		ate.leave();
		step(rnd(), 1'($random(seed)), 1'($random(seed)), 0);
		ate.enter(1'b1);
		step(rnd(), 1'b0, 1'b0, 1);
		done("newer port mode");
		// Core reset in test mode; straps left high must not re-enter
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		step(rnd(), 1'($random(seed)), 1'($random(seed)), 0);
		rst_n = 1'b1;
		step(rnd(), 1'b0, 1'b0, 0);
		done("mid-run reset");
		repeat (2) @(posedge clk);
		end_of_test();
	end
endmodule : tb
